//--- hdl/fisp_consts.vh
// Purpose: Shared constants for the fault flag, interrupt and status pin block.
// Assumes: Included by the pulse generator and top design files of the block.
// Notes:   Source indices fix the bit order of the flag, mask and clear vectors.
`ifndef FISP_CONSTS_VH
`define FISP_CONSTS_VH
`define FISP_NSRC        25
`define FISP_CV          0
`define FISP_DONE        1
`define FISP_IINLIM      2
`define FISP_DPPM        3
`define FISP_VINDPM      4
`define FISP_THERM       5
`define FISP_SV          6
`define FISP_OVP         7
`define FISP_OCP         8
`define FISP_UVLO        9
`define FISP_COLD        10
`define FISP_COOL        11
`define FISP_WARM        12
`define FISP_HOT         13
`define FISP_ADC         14
`define FISP_CMPA        15
`define FISP_CMPB        16
`define FISP_CMPC        17
`define FISP_OPEN        18
`define FISP_WD          19
`define FISP_ST          20
`define FISP_LDO         21
`define FISP_WAKE1       22
`define FISP_WAKE2       23
`define FISP_RSTWARN     24
`define FISP_CLK_MHZ     20
`define FISP_PULSE_US    128
`define FISP_PULSE_CYC   (`FISP_PULSE_US * `FISP_CLK_MHZ)
`define FISP_GAP_NS      1000
`define FISP_GAP_CYC     ((`FISP_GAP_NS * `FISP_CLK_MHZ + 999) / 1000)
`define FISP_CNT_W       12
`define FISP_PEND_W      8
`define FISP_PIN_MIRROR  2'h1
`define FISP_PIN_GPO_BIT 1
`endif

//--- hdl/fisp_flag_cell.v
// Purpose: One sticky flag with edge trigger output; its mask and allow inputs are unused.
// Assumes: Inputs synchronous to clk; clear is the host read of this flag.
// Notes:   A new trigger in the clearing cycle keeps the flag set.
`timescale 1ns/1ps
module fisp_flag_cell #(
  parameter BOTH_EDGES = 0
) (
  input  wire clk,
  input  wire arst_n,
  input  wire ce,
  input  wire cond,
  input  wire mask,
  input  wire clear,
  input  wire allow,
  output wire flag,
  output wire trig
);
  reg condPrev_reg;
  reg flag_reg;
  reg flag_next;

  assign trig = (BOTH_EDGES != 0) ? (cond ^ condPrev_reg) : (cond & ~condPrev_reg);
  assign flag = flag_reg;

  always @* begin
    flag_next = flag_reg;
    if (trig) begin
      flag_next = 1'b1;
    end else if (clear) begin
      flag_next = 1'b0;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      condPrev_reg <= 1'b0;
      flag_reg     <= 1'b0;
    end else if (ce) begin
      condPrev_reg <= cond;
      flag_reg     <= flag_next;
    end
  end
endmodule

//--- hdl/fisp_pulse_gen.v
// Purpose: Counts interrupt requests and plays them out as timed low pulses.
// Assumes: Requests are one-cycle pulses; several may arrive in one cycle.
// Notes:   A short released gap separates pulses so the host sees each one.
`timescale 1ns/1ps
`include "fisp_consts.vh"
module fisp_pulse_gen #(
  parameter N   = `FISP_NSRC,
  parameter PW  = `FISP_PULSE_CYC,
  parameter GAP = `FISP_GAP_CYC
) (
  input  wire         clk,
  input  wire         arst_n,
  input  wire         ce,
  input  wire [N-1:0] reqVec,
  output wire         intOe
);
  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_LOW  = 3'h2;
  localparam [2:0] S_GAP  = 3'h4;
  localparam integer           PW_M1    = PW - 1;
  localparam integer           GAP_M1   = GAP - 1;
  localparam [`FISP_CNT_W-1:0] PW_LAST  = PW_M1[`FISP_CNT_W-1:0];
  localparam [`FISP_CNT_W-1:0] GAP_LAST = GAP_M1[`FISP_CNT_W-1:0];

  reg [2:0]              state_reg;
  reg [2:0]              state_next;
  reg [`FISP_CNT_W-1:0]  count_reg;
  reg [`FISP_CNT_W-1:0]  count_next;
  reg [`FISP_PEND_W-1:0] pending_reg;
  reg [`FISP_PEND_W-1:0] pending_next;
  reg [5:0]              reqCount;
  reg [`FISP_PEND_W:0]   pendSum;
  reg                    take;
  reg                    intOe_reg;
  integer                i;

  assign intOe = intOe_reg;

  always @* begin
    reqCount = 6'h00;
    for (i = 0; i < N; i = i + 1) begin
      reqCount = reqCount + {5'h00, reqVec[i]};
    end
  end

  // Width is timed by counting clk cycles, each pending request gets its own pulse.
  always @* begin
    state_next = state_reg;
    count_next = count_reg;
    take       = 1'b0;
    case (state_reg)
      S_IDLE: begin
        if (pending_reg != {`FISP_PEND_W{1'b0}}) begin
          take       = 1'b1;
          state_next = S_LOW;
          count_next = {`FISP_CNT_W{1'b0}};
        end
      end
      S_LOW: begin
        if (count_reg == PW_LAST) begin
          state_next = S_GAP;
          count_next = {`FISP_CNT_W{1'b0}};
        end else begin
          count_next = count_reg + 1'b1;
        end
      end
      S_GAP: begin
        if (count_reg == GAP_LAST) begin
          state_next = S_IDLE;
        end else begin
          count_next = count_reg + 1'b1;
        end
      end
      default: begin
        state_next = S_IDLE;
        count_next = {`FISP_CNT_W{1'b0}};
      end
    endcase
    pendSum = {1'b0, pending_reg} + {3'h0, reqCount} - {{`FISP_PEND_W{1'b0}}, take};
    if (pendSum[`FISP_PEND_W]) begin
      pending_next = {`FISP_PEND_W{1'b1}};
    end else begin
      pending_next = pendSum[`FISP_PEND_W-1:0];
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg   <= S_IDLE;
      count_reg   <= {`FISP_CNT_W{1'b0}};
      pending_reg <= {`FISP_PEND_W{1'b0}};
      intOe_reg   <= 1'b0;
    end else if (ce) begin
      state_reg   <= state_next;
      count_reg   <= count_next;
      pending_reg <= pending_next;
      intOe_reg   <= (state_next == S_LOW);
    end
  end
endmodule

//--- hdl/fisp_top.v
// Purpose: Fault and event flags, interrupt pulse pin, fault response, status pin.
// Assumes: All inputs synchronous to clk; clear bits are one-cycle host read strobes.
// Notes:   Open-drain pins drive low only; the oe output is high while pulling low.
`timescale 1ns/1ps
`include "fisp_consts.vh"
module fisp_top #(
  parameter N = `FISP_NSRC
) (
  input  wire         clk,
  input  wire         arst_n,
  input  wire         ce,
  input  wire         startupDone,
  input  wire         startupFault,
  input  wire         constVoltageIn,
  input  wire         chargeDoneIn,
  input  wire         inputCurrentLoopIn,
  input  wire         pathMgmtLoopIn,
  input  wire         inputVoltageLoopIn,
  input  wire         thermalFoldbackIn,
  input  wire         supply_valid_status,
  input  wire         inputOvervoltageIn,
  input  wire         batteryOvercurrentIn,
  input  wire         batteryUndervoltageIn,
  input  wire         thermColdIn,
  input  wire         thermCoolIn,
  input  wire         thermWarmIn,
  input  wire         thermHotIn,
  input  wire         convReadyIn,
  input  wire         compareAlarmAIn,
  input  wire         compareAlarmBIn,
  input  wire         compareAlarmCIn,
  input  wire         thermOpenIn,
  input  wire         busWatchdogIn,
  input  wire         chargeTimerExpiredIn,
  input  wire         regulatorOvercurrentIn,
  input  wire         buttonWakeFirstIn,
  input  wire         buttonWakeSecondIn,
  input  wire         buttonResetWarnIn,
  input  wire         die_overtemp_shutdown,
  input  wire         chargeEnableIn_n,
  input  wire         rechargeThresholdIn,
  input  wire         timerDoubleOption,
  input  wire         regulatorEnableIn,
  input  wire         inputAboveUvlo,
  input  wire         inputAboveBatSleep,
  input  wire         inputBelowOvp,
  input  wire         pushbutton_in_n,
  input  wire [1:0]   status_pin_function,
  input  wire         status_pin_level,
  input  wire [N-1:0] maskIn,
  input  wire [N-1:0] flagReadClear,
  output wire [N-1:0] flagOut,
  output wire         intPinOut,
  output wire         intPinOe,
  output wire         supply_ok_out_n,
  output wire         supplyOkOe,
  output wire         chargeEnable,
  output wire         chargePause,
  output wire         chargeCurrentReduce,
  output wire         batRegReduce,
  output wire         chargeTimerReset,
  output wire         chargeTimerPause,
  output wire         chargeTimerDouble,
  output wire         chargeTimerEnable,
  output wire         regulatorEnable,
  output wire         systemRailEnable,
  output wire         system_rail_mode,
  output wire         batteryDisconnect
);
  wire [N-1:0] condVec;
  wire [N-1:0] trigVec;
  wire [N-1:0] reqVec;
  wire [N-1:0] allowVec;
  wire [N-1:0] flagVec;
  wire         intOeRaw;
  wire         inputOk;
  wire         supplyToggle;
  wire         ceToggle;
  wire         loopActive;

  reg startSeen_reg;
  reg armed_reg;
  reg svSuppress_reg;
  reg svPrev_reg;
  reg cePrev_reg;
  reg doneHold_reg;
  reg expiredHold_reg;
  reg intPinOut_reg;
  reg supplyOkOut_reg;
  reg supplyOkOe_reg;
  reg supplyOkOe_next;
  reg chargeEnable_reg;
  reg chargePause_reg;
  reg chargeCurrentReduce_reg;
  reg batRegReduce_reg;
  reg chargeTimerReset_reg;
  reg chargeTimerPause_reg;
  reg chargeTimerDouble_reg;
  reg chargeTimerEnable_reg;
  reg regulatorEnable_reg;
  reg systemRailEnable_reg;
  reg systemRailMode_reg;
  reg batteryDisconnect_reg;

  assign condVec[`FISP_CV]      = constVoltageIn;
  assign condVec[`FISP_DONE]    = chargeDoneIn;
  assign condVec[`FISP_IINLIM]  = inputCurrentLoopIn;
  assign condVec[`FISP_DPPM]    = pathMgmtLoopIn;
  assign condVec[`FISP_VINDPM]  = inputVoltageLoopIn;
  assign condVec[`FISP_THERM]   = thermalFoldbackIn;
  assign condVec[`FISP_SV]      = supply_valid_status;
  assign condVec[`FISP_OVP]     = inputOvervoltageIn;
  assign condVec[`FISP_OCP]     = batteryOvercurrentIn;
  assign condVec[`FISP_UVLO]    = batteryUndervoltageIn;
  assign condVec[`FISP_COLD]    = thermColdIn;
  assign condVec[`FISP_COOL]    = thermCoolIn;
  assign condVec[`FISP_WARM]    = thermWarmIn;
  assign condVec[`FISP_HOT]     = thermHotIn;
  assign condVec[`FISP_ADC]     = convReadyIn;
  assign condVec[`FISP_CMPA]    = compareAlarmAIn;
  assign condVec[`FISP_CMPB]    = compareAlarmBIn;
  assign condVec[`FISP_CMPC]    = compareAlarmCIn;
  assign condVec[`FISP_OPEN]    = thermOpenIn;
  assign condVec[`FISP_WD]      = busWatchdogIn;
  assign condVec[`FISP_ST]      = chargeTimerExpiredIn;
  assign condVec[`FISP_LDO]     = regulatorOvercurrentIn;
  assign condVec[`FISP_WAKE1]   = buttonWakeFirstIn;
  assign condVec[`FISP_WAKE2]   = buttonWakeSecondIn;
  assign condVec[`FISP_RSTWARN] = buttonResetWarnIn;

  // Only the supply-valid source may be held back at a low-battery power-up.
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : gCell
      assign allowVec[g] = armed_reg & ~((g == `FISP_SV) & svSuppress_reg);
      assign reqVec[g]   = trigVec[g] & allowVec[g] & ~maskIn[g]
                         & (~flagVec[g] | flagReadClear[g]);
      fisp_flag_cell #(
        .BOTH_EDGES ((g == `FISP_SV) ? 1 : 0)
      ) uCell (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .cond   (condVec[g]),
        .mask   (maskIn[g]),
        .clear  (flagReadClear[g]),
        .allow  (allowVec[g]),
        .flag   (flagVec[g]),
        .trig   (trigVec[g])
      );
    end
  endgenerate

  fisp_pulse_gen #(
    .N   (N),
    .PW  (`FISP_PULSE_CYC),
    .GAP (`FISP_GAP_CYC)
  ) uPulse (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .reqVec (reqVec),
    .intOe  (intOeRaw)
  );

  assign flagOut      = flagVec;
  assign intPinOut    = intPinOut_reg;
  assign intPinOe     = intOeRaw;
  assign supplyToggle = supply_valid_status ^ svPrev_reg;
  assign ceToggle     = chargeEnableIn_n ^ cePrev_reg;
  assign inputOk      = inputAboveUvlo & inputAboveBatSleep & inputBelowOvp;
  assign loopActive   = inputCurrentLoopIn | pathMgmtLoopIn | inputVoltageLoopIn
                      | thermalFoldbackIn;

  // A start-up that ends in a fault leaves interrupts off until the next reset.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      startSeen_reg  <= 1'b0;
      armed_reg      <= 1'b0;
      svSuppress_reg <= 1'b0;
    end else if (ce) begin
      startSeen_reg <= startSeen_reg | startupDone;
      if (startupDone & ~startSeen_reg & ~startupFault) begin
        armed_reg <= 1'b1;
      end
      if (startupDone & ~startSeen_reg) begin
        svSuppress_reg <= supply_valid_status & batteryUndervoltageIn;
      end else if (~supply_valid_status | ~batteryUndervoltageIn) begin
        svSuppress_reg <= 1'b0;
      end
    end
  end

  // Held charger states; a toggle of supply or enable releases both.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      svPrev_reg      <= 1'b0;
      cePrev_reg      <= 1'b0;
      doneHold_reg    <= 1'b0;
      expiredHold_reg <= 1'b0;
    end else if (ce) begin
      svPrev_reg <= supply_valid_status;
      cePrev_reg <= chargeEnableIn_n;
      if (trigVec[`FISP_DONE]) begin
        doneHold_reg <= 1'b1;
      end else if (supplyToggle | ceToggle | rechargeThresholdIn) begin
        doneHold_reg <= 1'b0;
      end
      if (trigVec[`FISP_ST]) begin
        expiredHold_reg <= 1'b1;
      end else if (supplyToggle | ceToggle) begin
        expiredHold_reg <= 1'b0;
      end
    end
  end

  // Status pin selection; the bit-1 function overrides the mirror setting.
  always @* begin
    if (status_pin_function[`FISP_PIN_GPO_BIT]) begin
      supplyOkOe_next = ~status_pin_level;
    end else if (status_pin_function == `FISP_PIN_MIRROR) begin
      supplyOkOe_next = ~pushbutton_in_n;
    end else begin
      supplyOkOe_next = inputOk;
    end
  end

  // Responses are registered so every output leaves from a flop; one cycle late.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      intPinOut_reg           <= 1'b0;
      supplyOkOut_reg         <= 1'b0;
      supplyOkOe_reg          <= 1'b0;
      chargeEnable_reg        <= 1'b0;
      chargePause_reg         <= 1'b0;
      chargeCurrentReduce_reg <= 1'b0;
      batRegReduce_reg        <= 1'b0;
      chargeTimerReset_reg    <= 1'b0;
      chargeTimerPause_reg    <= 1'b0;
      chargeTimerDouble_reg   <= 1'b0;
      chargeTimerEnable_reg   <= 1'b0;
      regulatorEnable_reg     <= 1'b0;
      systemRailEnable_reg    <= 1'b0;
      systemRailMode_reg      <= 1'b0;
      batteryDisconnect_reg   <= 1'b0;
    end else if (ce) begin
      intPinOut_reg           <= 1'b0;
      supplyOkOut_reg         <= 1'b0;
      supplyOkOe_reg          <= supplyOkOe_next;
      chargeEnable_reg        <= supply_valid_status & ~batteryOvercurrentIn
                               & ~expiredHold_reg & ~die_overtemp_shutdown;
      chargePause_reg         <= doneHold_reg | inputOvervoltageIn | thermColdIn
                               | thermHotIn | thermOpenIn;
      chargeCurrentReduce_reg <= loopActive | thermCoolIn;
      batRegReduce_reg        <= thermWarmIn;
      chargeTimerReset_reg    <= doneHold_reg | ~supply_valid_status | inputOvervoltageIn
                               | (expiredHold_reg & ~flagVec[`FISP_ST]);
      chargeTimerPause_reg    <= thermColdIn | thermHotIn | thermOpenIn;
      chargeTimerDouble_reg   <= timerDoubleOption & (loopActive | thermCoolIn);
      chargeTimerEnable_reg   <= ~die_overtemp_shutdown;
      regulatorEnable_reg     <= regulatorEnableIn & ~die_overtemp_shutdown;
      systemRailEnable_reg    <= ~die_overtemp_shutdown;
      systemRailMode_reg      <= inputOvervoltageIn;
      batteryDisconnect_reg   <= batteryOvercurrentIn;
    end
  end

  assign supply_ok_out_n     = supplyOkOut_reg;
  assign supplyOkOe          = supplyOkOe_reg;
  assign chargeEnable        = chargeEnable_reg;
  assign chargePause         = chargePause_reg;
  assign chargeCurrentReduce = chargeCurrentReduce_reg;
  assign batRegReduce        = batRegReduce_reg;
  assign chargeTimerReset    = chargeTimerReset_reg;
  assign chargeTimerPause    = chargeTimerPause_reg;
  assign chargeTimerDouble   = chargeTimerDouble_reg;
  assign chargeTimerEnable   = chargeTimerEnable_reg;
  assign regulatorEnable     = regulatorEnable_reg;
  assign systemRailEnable    = systemRailEnable_reg;
  assign system_rail_mode    = systemRailMode_reg;
  assign batteryDisconnect   = batteryDisconnect_reg;
endmodule

//--- sim/fault_interrupt_and_status_pin_test.sv
// Purpose: Self-checking bench for the fault flag, interrupt and status pin block.
// Assumes: ce is dropped only while the interrupt pin is idle.
// Notes:   Each pulse costs 2560 cycles, so only a few are played out.
`timescale 1ns/1ps
`include "fisp_consts.vh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("BAD %s expected %0h saw %0h", nm, ex, got); end end
module fault_interrupt_and_status_pin_test;
  typedef struct packed {logic [11:0] r; logic [7:0] p; logic [15:0] e;} fisp_row_t;
  logic        clk, arst_n, startupDone, startupFault, die_overtemp_shutdown;
  logic        timerDoubleOption, status_pin_level, pushbutton_in_n, ce;
  logic        chargeEnableIn_n, rechargeThresholdIn, regulatorEnableIn;
  logic        inputAboveUvlo, inputAboveBatSleep, inputBelowOvp;
  logic [1:0]  status_pin_function;
  logic [24:0] cond, maskIn;
  wire  [24:0] flagOut, flagReadClear;
  wire  [11:0] resp;
  wire         intPinOut, intPinOe, supply_ok_out_n, supplyOkOe;
  int          pulses, width, n_mismatch = 0, samples_checked = 0;
  fisp_row_t   rows [21] = '{'{12'h002, 8'h0F, 16'h1C9E}, '{12'h001, 8'h0F, 16'h101D},
    '{12'h010, 8'h0F, 16'h1C5C}, '{12'h008, 8'h0F, 16'h1C5C}, '{12'h004, 8'h0F, 16'h1C5C},
    '{12'h180, 8'h0F, 16'h1A3C}, '{12'h040, 8'h0F, 16'h1A1C}, '{12'h020, 8'h0F, 16'h191C},
    '{12'h400, 8'h0F, 16'h181C}, '{12'h200, 8'h0F, 16'h1000}, '{12'h800, 8'h0F, 16'h181C},
    '{12'h000, 8'h0B, 16'h081C}, '{12'h000, 8'h0D, 16'h081C}, '{12'h000, 8'h0E, 16'h081C},
    '{12'h000, 8'h2F, 16'h081C}, '{12'h000, 8'h20, 16'h181C}, '{12'h000, 8'h40, 16'h181C},
    '{12'h000, 8'h57, 16'h081C}, '{12'h000, 8'h60, 16'h181C}, '{12'h000, 8'h77, 16'h081C},
    '{12'h000, 8'h0F, 16'h181C}};
  fisp_top uut (
    .clk, .arst_n, .ce, .startupDone, .startupFault,
    .constVoltageIn(cond[0]), .chargeDoneIn(cond[1]), .inputCurrentLoopIn(cond[2]),
    .pathMgmtLoopIn(cond[3]), .inputVoltageLoopIn(cond[4]), .thermalFoldbackIn(cond[5]),
    .supply_valid_status(cond[6]), .inputOvervoltageIn(cond[7]),
    .batteryOvercurrentIn(cond[8]), .batteryUndervoltageIn(cond[9]), .thermColdIn(cond[10]),
    .thermCoolIn(cond[11]), .thermWarmIn(cond[12]), .thermHotIn(cond[13]),
    .convReadyIn(cond[14]), .compareAlarmAIn(cond[15]), .compareAlarmBIn(cond[16]),
    .compareAlarmCIn(cond[17]), .thermOpenIn(cond[18]), .busWatchdogIn(cond[19]),
    .chargeTimerExpiredIn(cond[20]), .regulatorOvercurrentIn(cond[21]),
    .buttonWakeFirstIn(cond[22]), .buttonWakeSecondIn(cond[23]), .buttonResetWarnIn(cond[24]),
    .die_overtemp_shutdown, .chargeEnableIn_n, .rechargeThresholdIn,
    .timerDoubleOption, .regulatorEnableIn, .inputAboveUvlo, .inputAboveBatSleep,
    .inputBelowOvp, .pushbutton_in_n, .status_pin_function, .status_pin_level, .maskIn,
    .flagReadClear, .flagOut, .intPinOut, .intPinOe, .supply_ok_out_n, .supplyOkOe,
    .chargeEnable(resp[11]), .chargePause(resp[10]), .chargeCurrentReduce(resp[9]),
    .batRegReduce(resp[8]), .chargeTimerReset(resp[7]), .chargeTimerPause(resp[6]),
    .chargeTimerDouble(resp[5]), .chargeTimerEnable(resp[4]), .regulatorEnable(resp[3]),
    .systemRailEnable(resp[2]), .system_rail_mode(resp[1]), .batteryDisconnect(resp[0]));
  fisp_host_model #(.N(25)) host (.clk, .arst_n, .intPinOut, .intPinOe, .flagReadClear,
    .pulseCount(pulses), .lastWidth(width));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic setc(input logic [24:0] v);
    @(posedge clk);
    cond <= v;
  endtask
  task automatic wait_pulses(input int n, input int bound);
    int k;
    k = 0;
    while (pulses < n && k < bound) begin
      @(posedge clk);
      k++;
    end
    `CHK("pulse count", n, pulses)
    if (pulses < n) final_report();
  endtask
  // Supply stays valid in every row, so the hold states never mask a response.
  task automatic apply_row(input fisp_row_t w);
    logic [24:0] c;
    c = w.r[11] ? 25'h1CBC041 : 25'h0000040;
    c[8] = w.r[0];
    c[7] = w.r[1];
    c[18] = w.r[2];
    c[13] = w.r[3];
    c[10] = w.r[4];
    c[12] = w.r[5];
    c[11] = w.r[6];
    c[5:2] = {4{w.r[7]}};
    c[21] = w.r[10];
    @(posedge clk);
    cond <= c;
    {die_overtemp_shutdown, timerDoubleOption} <= w.r[9:8];
    {status_pin_function, status_pin_level, pushbutton_in_n} <= w.p[6:3];
    {inputAboveUvlo, inputAboveBatSleep, inputBelowOvp} <= w.p[2:0];
    repeat (2) @(posedge clk);
    #1;
    `CHK("row", w.e[12:0], {supplyOkOe, resp})
    `CHK("status out", 1'b0, supply_ok_out_n)
  endtask
  initial begin
    {arst_n, startupDone, startupFault, die_overtemp_shutdown, timerDoubleOption} = 5'h00;
    {ce, chargeEnableIn_n, rechargeThresholdIn, regulatorEnableIn} = 4'hD;
    {status_pin_function, status_pin_level, pushbutton_in_n} = 4'h3;
    {inputAboveUvlo, inputAboveBatSleep, inputBelowOvp} = 3'h7;
    cond = 25'h0000040;
    maskIn = 25'h1FFFFFF;
    repeat (4) @(posedge clk);
    #1;
    `CHK("reset outputs", 39'h0, {intPinOe, supplyOkOe, resp, flagOut})
    `CHK("reset pins", 2'h0, {intPinOut, supply_ok_out_n})
    @(posedge clk);
    arst_n <= 1'b1;
    foreach (rows[i]) apply_row(rows[i]);
    host.read_flags(25'h1FFFFFF);
    maskIn <= 25'h0;
    setc(25'h0000042);
    repeat (10) @(posedge clk);
    #1;
    `CHK("pulses before start-up", 0, pulses)
    `CHK("done flag", 1'b1, flagOut[1])
    setc(25'h0000040);
    host.read_flags(25'h1FFFFFF);
    startupDone <= 1'b1;
    @(posedge clk);
    setc(25'h0000042);
    wait_pulses(1, 3000);
    `CHK("pulse width", `FISP_PULSE_CYC, width)
    maskIn <= 25'h0000001;
    setc(25'h0000043);
    repeat (20) @(posedge clk);
    maskIn <= 25'h0;
    repeat (20) @(posedge clk);
    #1;
    `CHK("masked then unmasked", 1, pulses)
    `CHK("cv flag", 1'b1, flagOut[0])
    setc(25'h0000041);
    setc(25'h0000043);
    repeat (20) @(posedge clk);
    #1;
    `CHK("trigger on unread flag", 1, pulses)
    host.read_flags(25'h0000002);
    setc(25'h0000041);
    setc(25'h000C043);
    wait_pulses(4, 9000);
    `CHK("back to back width", `FISP_PULSE_CYC, width)
    host.read_flags(25'h1FFFFFF);
    setc(25'h0);
    wait_pulses(5, 3000);
    host.read_flags(25'h0000040);
    setc(25'h0000040);
    wait_pulses(6, 3000);
    ce <= 1'b0;
    regulatorEnableIn <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("frozen by ce", 1'b1, resp[3])
    @(posedge clk);
    ce <= 1'b1;
    maskIn <= 25'h0100002;
    setc(25'h0000042);
    repeat (3) @(posedge clk);
    #1;
    `CHK("regulator off", 1'b0, resp[3])
    `CHK("done pause", 1'b1, resp[10])
    @(posedge clk);
    chargeEnableIn_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("enable toggle", 1'b0, resp[10])
    setc(25'h0000040);
    setc(25'h0000042);
    rechargeThresholdIn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("recharge", 1'b0, resp[10])
    setc(25'h0100040);
    repeat (3) @(posedge clk);
    #1;
    `CHK("timer expired", 2'h0, {resp[11], resp[7]})
    host.read_flags(25'h0100000);
    repeat (2) @(posedge clk);
    #1;
    `CHK("timer reset", 2'h1, {resp[11], resp[7]})
    repeat (30) @(posedge clk);
    arst_n <= 1'b0;
    startupDone <= 1'b0;
    cond <= 25'h0000240;
    maskIn <= 25'h1FFFFBF;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    startupDone <= 1'b1;
    host.read_flags(25'h1FFFFFF);
    setc(25'h0000200);
    repeat (20) @(posedge clk);
    #1;
    `CHK("low battery power-up", 0, pulses)
    `CHK("supply flag", 1'b1, flagOut[6])
    final_report();
  end
endmodule

//--- sim/fisp_host_model.sv
// Purpose: Host side: counts interrupt pulses and clears flags by reading them.
// Assumes: The interrupt line has a pull-up; the design only pulls it low.
// Notes:   Width is the number of clock cycles the line stays low.
`timescale 1ns/1ps
module fisp_host_model #(
  parameter N = 25
) (
  input  wire logic    clk,
  input  wire logic    arst_n,
  input  wire logic    intPinOut,
  input  wire logic    intPinOe,
  output logic [N-1:0] flagReadClear,
  output int           pulseCount,
  output int           lastWidth
);
  wire intLine = intPinOe ? intPinOut : 1'b1;
  int  lowCount;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lowCount <= 0;
      pulseCount <= 0;
      lastWidth <= 0;
    end else if (!intLine) begin
      lowCount <= lowCount + 1;
    end else if (lowCount != 0) begin
      pulseCount <= pulseCount + 1;
      lastWidth <= lowCount;
      lowCount <= 0;
    end
  end
  // A read clears exactly the flags it returns, for one cycle.
  task automatic read_flags(input logic [N-1:0] bits);
    @(posedge clk);
    flagReadClear <= bits;
    @(posedge clk);
    flagReadClear <= '0;
  endtask
  initial flagReadClear = '0;
endmodule

//--- sim/fisp_properties.sv
// Purpose: Temporal checks on the interrupt pulse, the flags and the fault response.
// Assumes: ce is dropped only while the pin is idle and inputs are steady.
// Notes:   A 12-bit width counter is enough for one full pulse.
`timescale 1ns/1ps
module fisp_checker #(
  parameter N = 25
) (
  input wire logic         clk,
  input wire logic         arst_n,
  input wire logic         startupDone,
  input wire logic         supply_valid_status,
  input wire logic         inputOvervoltageIn,
  input wire logic         batteryOvercurrentIn,
  input wire logic         die_overtemp_shutdown,
  input wire logic [1:0]   status_pin_function,
  input wire logic         status_pin_level,
  input wire logic [N-1:0] flagReadClear,
  input wire logic [N-1:0] flagOut,
  input wire logic         intPinOe,
  input wire logic         supplyOkOe,
  input wire logic         chargeEnable,
  input wire logic         chargePause,
  input wire logic         chargeTimerReset,
  input wire logic         system_rail_mode,
  input wire logic         batteryDisconnect,
  input wire logic         regulatorEnable,
  input wire logic         systemRailEnable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [11:0] hiCount_reg;
  logic        everDone_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hiCount_reg  <= 12'h000;
      everDone_reg <= 1'b0;
    end else begin
      hiCount_reg  <= intPinOe ? hiCount_reg + 12'h001 : 12'h000;
      everDone_reg <= everDone_reg | startupDone;
    end
  end
  property p_pulse_width;
    $fell(intPinOe) |-> hiCount_reg == 12'hA00;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong");
  property p_prearm;
    !everDone_reg |-> !intPinOe;
  endproperty
  a_prearm: assert property (p_prearm) else $error("pulse before start-up");
  property p_flag_hold;
    1'b1 |=> ((~flagOut & $past(flagOut) & ~$past(flagReadClear)) == '0);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost without read");
  property p_sv_both;
    $changed(supply_valid_status) |=> flagOut[6];
  endproperty
  a_sv_both: assert property (p_sv_both) else $error("supply flag missed");
  property p_ovp;
    inputOvervoltageIn |=> chargePause && chargeTimerReset && system_rail_mode;
  endproperty
  a_ovp: assert property (p_ovp) else $error("overvoltage response wrong");
  property p_ocp;
    batteryOvercurrentIn |=> !chargeEnable && batteryDisconnect;
  endproperty
  a_ocp: assert property (p_ocp) else $error("overcurrent response wrong");
  property p_die;
    die_overtemp_shutdown |=> !chargeEnable && !regulatorEnable && !systemRailEnable;
  endproperty
  a_die: assert property (p_die) else $error("shutdown response wrong");
  property p_gpo;
    status_pin_function[1] |=> supplyOkOe != $past(status_pin_level);
  endproperty
  a_gpo: assert property (p_gpo) else $error("status pin output wrong");
endmodule
bind fisp_top fisp_checker #(.N(N)) chk (.clk, .arst_n, .startupDone, .supply_valid_status,
  .inputOvervoltageIn, .batteryOvercurrentIn, .die_overtemp_shutdown, .status_pin_function,
  .status_pin_level, .flagReadClear, .flagOut, .intPinOe, .supplyOkOe, .chargeEnable,
  .chargePause, .chargeTimerReset, .system_rail_mode, .batteryDisconnect, .regulatorEnable,
  .systemRailEnable);
